// [logic/dcl_pkg.sv]
// Shared constants for the host controller of the dual counter/latch/byte scanner.
// Assumes a single 20 MHz clock; all pin timings are turned into cycle counts here.
package dcl_pkg;

    // ==========================================================================
    // Clock and pin timings
    // ==========================================================================
    localparam int CLK_NS          = 50;    // 20 MHz
    localparam int RST_LOW_NS      = 1000;  // Counter reset low time
    localparam int RST_RECOVER_NS  = 300;   // Reset high before next count
    localparam int LOAD_LOW_MIN_NS = 1000;  // Scan reset/load pulse
    localparam int RIPPLE_NS       = 2000;  // Ripple settle after last count edge
    localparam int LOAD_REMOVE_NS  = 250;   // Load removal time
    localparam int SCAN_PULSE_NS   = 500;   // Scan high and low widths

    // Least times round up to whole cycles
    localparam int RST_LOW_CYC     = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_RECOVER_CYC = (RST_RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOAD_LOW_CYC    = (((RIPPLE_NS > LOAD_LOW_MIN_NS) ? RIPPLE_NS : LOAD_LOW_MIN_NS)
                                      + CLK_NS - 1) / CLK_NS;
    localparam int LOAD_REMOVE_CYC = (LOAD_REMOVE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCAN_CYC        = (SCAN_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // ==========================================================================
    // Widths and word layout
    // ==========================================================================
    localparam int TMR_W      = 6;
    localparam int BYTE_W     = 8;
    localparam int NUM_BYTES  = 4;
    localparam int WORD_W     = 32;
    localparam int SYNC_W     = 9;      // Byte bus plus cascade
    localparam int CASCADE_BIT = 8;

    localparam logic [TMR_W-1:0] RST_LOW_T     = TMR_W'(RST_LOW_CYC - 1);
    localparam logic [TMR_W-1:0] RST_RECOVER_T = TMR_W'(RST_RECOVER_CYC - 1);
    localparam logic [TMR_W-1:0] LOAD_LOW_T    = TMR_W'(LOAD_LOW_CYC - 1);
    localparam logic [TMR_W-1:0] LOAD_REMOVE_T = TMR_W'(LOAD_REMOVE_CYC - 1);
    localparam logic [TMR_W-1:0] SCAN_T        = TMR_W'(SCAN_CYC - 1);
    localparam logic [1:0]       LAST_BYTE     = 2'h3;

    // ==========================================================================
    // Sequencer states, Gray coded along the usual path
    // ==========================================================================
    typedef enum logic [3:0] {
        DCL_IDLE    = 4'h0,
        DCL_CRST    = 4'h1,
        DCL_CWAIT   = 4'h3,
        DCL_LLOW    = 4'h2,
        DCL_LWAIT   = 4'h6,
        DCL_SHI     = 4'h7,
        DCL_SLO     = 4'h5,
        DCL_FIN     = 4'h4
    } dcl_state_type;

endpackage

// [logic/dcl_sync_if.sv]
// Carrier between the pin synchroniser and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dcl_sync_if;
    import dcl_pkg::*;
    logic [SYNC_W-1:0] raw;     // Pins as they arrive
    logic [SYNC_W-1:0] stable;  // Filtered, in the clock domain

    modport sync_end (input raw, output stable);
    modport user_end (output raw, input stable);
endinterface // dcl_sync_if

// [logic/dcl_sync.sv]
// Three-stage input filter for the pins coming back from the device.
// Assumes pins are asynchronous to clk; a change is taken once stages two and three agree.
`timescale 1ns/1ps
module dcl_sync
    import dcl_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    // Pin carrier
    dcl_sync_if.sync_end port_if
);

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] out;
    } dcl_sync_st_type;

    dcl_sync_st_type st_q;
    dcl_sync_st_type st_d;

    // ==========================================================================
    // Filter chain
    // ==========================================================================
    // First stage feeds only the second, so no logic sees a metastable value
    always_comb begin
        st_d    = st_q;
        st_d.s1 = port_if.raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    // Idle pins read high: cascade high means the device is not finished
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{s1: '1, s2: '1, s3: '1, out: '1};
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign port_if.stable = st_q.out;

endmodule // dcl_sync

// [logic/dcl_host.sv]
// Host sequencer that clears, latches and reads a dual 16-bit counter with byte scan output.
// Assumes the device pins are wired straight to the pin group; one device, no cascade beyond it.
`timescale 1ns/1ps
module dcl_host
    import dcl_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    // User commands
    input  wire logic                clear_req,
    input  wire logic                read_req,
    input  wire logic                count_b_in,
    // User results
    output logic                     busy,
    output logic [WORD_W-1:0]        word,
    output logic                     word_valid,
    output logic                     cascade_err,
    // Device pins
    output logic                     cnt_reset_n,
    output logic                     count_b,
    output logic                     load_n,
    output logic                     enable_n,
    output logic                     scan,
    input  wire logic [BYTE_W-1:0]   byte_bus_out,
    input  wire logic                cascade_in
);

    typedef struct packed {
        dcl_state_type      st;
        logic [TMR_W-1:0]   tmr;
        logic [1:0]         idx;
        logic [WORD_W-1:0]  word;
        logic               valid;
        logic               err;
        logic               cnt_reset_n;
        logic               count_b;
        logic               load_n;
        logic               enable_n;
        logic               scan;
        logic               busy;
    } dcl_host_st_type;

    dcl_host_st_type q;
    dcl_host_st_type d;
    dcl_sync_if      pins_if ();

    // ==========================================================================
    // Pin filter
    // ==========================================================================
    assign pins_if.raw = {cascade_in, byte_bus_out};

    dcl_sync u_sync (
        .clk     (clk),
        .resetn  (resetn),
        .ce      (ce),
        .port_if (pins_if.sync_end)
    );

    // Timer expiry test, used by every timed state
    function automatic logic tmr_done(input logic [TMR_W-1:0] t, input logic [TMR_W-1:0] lim);
        tmr_done = (t >= lim);
    endfunction

    // ==========================================================================
    // Sequencer
    // ==========================================================================
    always_comb begin
        d       = q;
        d.valid = 1'b0;
        d.tmr   = q.tmr + TMR_W'(1);
        // Count relay is gated off while the counter is held in reset
        d.count_b = count_b_in & q.cnt_reset_n & (q.st != DCL_CRST);
        // Relay frozen while latching and through the load removal time, so no count edge
        // disturbs the ripple settle; a B pulse lying wholly inside the freeze is lost
        if (q.st == DCL_LLOW || q.st == DCL_LWAIT) begin
            d.count_b = q.count_b;
        end
        case (q.st)
            DCL_IDLE: begin
                d.tmr = '0;
                if (clear_req) begin
                    d.st          = DCL_CRST;
                    d.cnt_reset_n = 1'b0;
                    d.count_b     = 1'b0;
                end else if (read_req) begin
                    d.st      = DCL_LLOW;
                    d.load_n  = 1'b0;
                    d.count_b = q.count_b;
                end
            end
            DCL_CRST: begin
                if (tmr_done(q.tmr, RST_LOW_T)) begin
                    d.st          = DCL_CWAIT;
                    d.tmr         = '0;
                    d.cnt_reset_n = 1'b1;
                end
            end
            DCL_CWAIT: begin
                // Recovery before the next count can register
                if (tmr_done(q.tmr, RST_RECOVER_T)) begin
                    d.st  = DCL_IDLE;
                    d.tmr = '0;
                end
            end
            DCL_LLOW: begin
                // Load held for the whole ripple time so the latched count is settled
                if (tmr_done(q.tmr, LOAD_LOW_T)) begin
                    d.st     = DCL_LWAIT;
                    d.tmr    = '0;
                    d.load_n = 1'b1;
                    d.err    = 1'b0;
                    d.idx    = '0;
                end
            end
            DCL_LWAIT: begin
                // Enable changes here, with scan low, to avoid a false step
                if (tmr_done(q.tmr, LOAD_REMOVE_T)) begin
                    d.enable_n = 1'b0;
                    if (!q.enable_n) begin
                        d.st   = DCL_SHI;
                        d.tmr  = '0;
                        d.scan = 1'b1;
                    end
                end
            end
            DCL_SHI: begin
                // Sample at the end of the high phase, after output delay and filtering
                if (tmr_done(q.tmr, SCAN_T)) begin
                    d.word[q.idx*BYTE_W +: BYTE_W] = pins_if.stable[BYTE_W-1:0];
                    d.st   = DCL_SLO;
                    d.tmr  = '0;
                    d.scan = 1'b0;
                end
            end
            DCL_SLO: begin
                if (tmr_done(q.tmr, SCAN_T)) begin
                    d.tmr = '0;
                    if (q.idx == LAST_BYTE) begin
                        d.st = DCL_FIN;
                    end else begin
                        d.st   = DCL_SHI;
                        d.idx  = q.idx + 2'h1;
                        d.scan = 1'b1;
                    end
                end
            end
            DCL_FIN: begin
                // Cascade must have fallen once the fourth byte was stepped past
                d.err      = pins_if.stable[CASCADE_BIT];
                d.enable_n = 1'b1;
                d.valid    = 1'b1;
                d.st       = DCL_IDLE;
                d.tmr      = '0;
            end
            default: begin
                d.st = DCL_IDLE;
            end
        endcase
        // Busy is registered so the output comes straight from a flop
        d.busy = (d.st != DCL_IDLE);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{st: DCL_IDLE, tmr: '0, idx: '0, word: '0, valid: 1'b0, err: 1'b0,
                   cnt_reset_n: 1'b1, count_b: 1'b0, load_n: 1'b1, enable_n: 1'b1, scan: 1'b0, busy: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    // Every output straight from the state register
    assign busy        = q.busy;
    assign word        = q.word;
    assign word_valid  = q.valid;
    assign cascade_err = q.err;
    assign cnt_reset_n = q.cnt_reset_n;
    assign count_b     = q.count_b;
    assign load_n      = q.load_n;
    assign enable_n    = q.enable_n;
    assign scan        = q.scan;

    // ==========================================================================
    // Checks (written for ce held high)
    // ==========================================================================
    logic [TMR_W-1:0] rst_lo_cnt;
    logic [TMR_W-1:0] ld_lo_cnt;
    logic [2:0]       scan_rises;
    logic [TMR_W-1:0] ld_hi_cnt;

    // Helper counters: low widths of reset and load, time since load release, scan pulses
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_lo_cnt <= '0;
            ld_lo_cnt  <= '0;
            scan_rises <= '0;
            ld_hi_cnt  <= '1;
        end else begin
            rst_lo_cnt <= q.cnt_reset_n ? '0 : rst_lo_cnt + TMR_W'(1);
            ld_lo_cnt  <= q.load_n ? '0 : ld_lo_cnt + TMR_W'(1);
            // Saturates so a long idle time never wraps back below the limit
            ld_hi_cnt  <= !q.load_n ? '0 : ((ld_hi_cnt == '1) ? ld_hi_cnt : ld_hi_cnt + TMR_W'(1));
            if (!q.load_n) begin
                scan_rises <= '0;
            end else if (d.scan && !q.scan) begin
                scan_rises <= scan_rises + 3'h1;
            end
        end
    end

    sequence s_scan_hold_hi;
        scan[*8] ##1 scan ##1 scan;
    endsequence

    sequence s_scan_hold_lo;
        !scan[*8] ##1 !scan ##1 !scan;
    endsequence

    a_reset_width: assert property (@(posedge clk) disable iff (!resetn)
        $rose(cnt_reset_n) |-> ($past(rst_lo_cnt) >= TMR_W'(RST_LOW_CYC - 1)))
        else $error("Counter reset released too early");

    a_countb_in_reset: assert property (@(posedge clk) disable iff (!resetn)
        !cnt_reset_n |-> !count_b)
        else $error("Count B not low during reset");

    a_reset_recovery: assert property (@(posedge clk) disable iff (!resetn)
        $rose(cnt_reset_n) |-> busy[*6])
        else $error("Ready before reset recovery");

    a_load_width: assert property (@(posedge clk) disable iff (!resetn)
        $rose(load_n) |-> ($past(ld_lo_cnt) >= TMR_W'(LOAD_LOW_CYC - 1)))
        else $error("Load released before ripple settled");

    a_enable_scan_low: assert property (@(posedge clk) disable iff (!resetn)
        $changed(enable_n) |-> (!scan && !$past(scan)))
        else $error("Enable changed while scan high");

    a_scan_high_width: assert property (@(posedge clk) disable iff (!resetn)
        $rose(scan) |-> s_scan_hold_hi)
        else $error("Scan high pulse too short");

    a_scan_low_width: assert property (@(posedge clk) disable iff (!resetn)
        $fell(scan) |-> s_scan_hold_lo)
        else $error("Scan low pulse too short");

    a_scan_enabled: assert property (@(posedge clk) disable iff (!resetn)
        scan |-> (!enable_n && load_n))
        else $error("Scan high while disabled or loading");

    a_four_bytes: assert property (@(posedge clk) disable iff (!resetn)
        $rose(word_valid) |-> (scan_rises == 3'h4))
        else $error("Word finished without four bytes");

    a_valid_pulse: assert property (@(posedge clk) disable iff (!resetn)
        word_valid |-> (!busy ##1 !word_valid))
        else $error("Word valid not a single pulse");

    a_count_after_load: assert property (@(posedge clk) disable iff (!resetn)
        $fell(count_b) |-> (load_n && (ld_hi_cnt >= TMR_W'(LOAD_REMOVE_CYC))))
        else $error("Count B fell too soon after load release");

endmodule // dcl_host

// [tb/dcl_dev_model.sv]
// Behavioural model of the dual 16-bit counter with 32-bit latch and byte scan bus.
// Assumes pins come straight from the host and the bench; no clock of its own.
`timescale 1ns/1ps
module dcl_dev_model (
    // Count pins
    input  wire logic       count_a,
    input  wire logic       alt_count_a,
    input  wire logic       count_b,
    // Control pins
    input  wire logic       cnt_reset_n,
    input  wire logic       load_n,
    input  wire logic       enable_n,
    input  wire logic       scan,
    // Fault injection: cascade never falls
    input  wire logic       stuck_cascade,
    // Outputs to the host
    output logic [7:0]      byte_bus_out,
    output logic            cascade_out
);
    // ==========================================================================
    // Counters and latch
    // ==========================================================================
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    logic [31:0] latch_q;
    logic [2:0]  state_q = 3'h5;
    logic [7:0]  last_q = 8'h00;
    wire         gate_a = count_a | alt_count_a;
    wire         drive = scan && !enable_n && (state_q != 3'h5);

    // Low half; a high on either input holds the gate high
    always @(negedge gate_a or negedge cnt_reset_n) begin
        if (!cnt_reset_n)
            lo_q <= 16'h0000;
        else
            lo_q <= lo_q + 16'h0001;
    end

    // High half on its own input
    always @(negedge count_b or negedge cnt_reset_n) begin
        if (!cnt_reset_n)
            hi_q <= 16'h0000;
        else
            hi_q <= hi_q + 16'h0001;
    end

    // Latch is transparent while load is low
    always @(*) begin
        if (!load_n)
            latch_q = {hi_q, lo_q};
    end

    // ==========================================================================
    // Scan counter and bus
    // ==========================================================================
    always @(negedge scan or negedge load_n) begin
        if (!load_n)
            state_q <= 3'h1;
        else if (!enable_n && state_q != 3'h5)
            state_q <= state_q + 3'h1;
    end

    // Released bus shows the inverse of the last byte, so a stale read is caught
    always @(*) begin
        if (drive) begin
            byte_bus_out = latch_q[8*(state_q-3'h1) +: 8];
            last_q = byte_bus_out;
        end else begin
            byte_bus_out = ~last_q;
        end
    end

    assign cascade_out = (state_q == 3'h5 && !stuck_cascade) ? 1'b0 : 1'b1;
endmodule // dcl_dev_model

// [tb/dual_counter_latch_byte_scanner_tb_top.sv]
// Self-checking bench for the host sequencer, with the device model on its pins.
// Assumes a 20 MHz clock; count pins are driven by the bench at falling edges.
`timescale 1ns/1ps
module dual_counter_latch_byte_scanner_tb_top;
    import dcl_pkg::*;
    // ==========================================================================
    // Signals
    // ==========================================================================
    logic              clk = 1'b0;
    logic              resetn, ce, clear_req, read_req, count_b_in;
    logic              count_a, alt_count_a, stuck_cascade;
    logic              busy, word_valid, cascade_err, cnt_reset_n;
    logic              count_b, load_n, enable_n, scan, cascade_in;
    logic [WORD_W-1:0] word;
    logic [BYTE_W-1:0] byte_bus_out;
    int                failures = 0;
    int                checks_done = 0;

    // 50 ns period
    always #25 clk = ~clk;

    dcl_host dut (.clk(clk), .resetn(resetn), .ce(ce), .clear_req(clear_req), .read_req(read_req),
        .count_b_in(count_b_in), .busy(busy), .word(word), .word_valid(word_valid),
        .cascade_err(cascade_err), .cnt_reset_n(cnt_reset_n), .count_b(count_b), .load_n(load_n),
        .enable_n(enable_n), .scan(scan), .byte_bus_out(byte_bus_out), .cascade_in(cascade_in));

    dcl_dev_model dev (.count_a(count_a), .alt_count_a(alt_count_a), .count_b(count_b),
        .cnt_reset_n(cnt_reset_n), .load_n(load_n), .enable_n(enable_n), .scan(scan),
        .stuck_cascade(stuck_cascade), .byte_bus_out(byte_bus_out), .cascade_out(cascade_in));

    // ==========================================================================
    // Shared tasks
    // ==========================================================================
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Mode 0 pulses the main input, 1 the alternate, 2 the main one with the alternate held high
    task automatic pulse_a(input int n, input int mode);
        repeat (n) begin
            @(negedge clk);
            count_a = (mode != 1);
            alt_count_a = (mode != 0);
            @(negedge clk);
            count_a = 1'b0;
            alt_count_a = (mode == 2);
        end
        @(negedge clk);
        alt_count_a = 1'b0;
    endtask

    task automatic pulse_b(input int n);
        repeat (n) begin
            @(negedge clk);
            count_b_in = 1'b1;
            @(negedge clk);
            count_b_in = 1'b0;
        end
        repeat (2) @(negedge clk);
    endtask

    // Toggles count_b_in early in the clear; it must never reach the pin then
    task automatic do_clear;
        int low_cyc;
        int b_high;
        int t;
        low_cyc = 0;
        b_high = 0;
        @(negedge clk);
        clear_req = 1'b1;
        @(negedge clk);
        clear_req = 1'b0;
        for (t = 0; t < 100 && busy === 1'b1; t++) begin
            if (cnt_reset_n === 1'b0)
                low_cyc++;
            if (cnt_reset_n === 1'b0 && count_b !== 1'b0)
                b_high++;
            @(negedge clk);
            count_b_in = (low_cyc < RST_LOW_CYC - 2) ? ~count_b_in : 1'b0;
        end
        check("cnt_reset_n low cycles", RST_LOW_CYC, low_cyc);
        check("count_b high in clear", 0, b_high);
        check("busy after clear", 1'b0, busy);
    endtask

    // One read; poke raises clear_req mid-read, which must be ignored
    task automatic do_read(input logic [31:0] exp, input logic exp_err, input logic poke);
        int load_low;
        int scans;
        int bad_en;
        int t;
        logic prev_scan;
        logic prev_en;
        load_low = 0;
        scans = 0;
        bad_en = 0;
        @(negedge clk);
        read_req = 1'b1;
        @(negedge clk);
        read_req = 1'b0;
        prev_scan = scan;
        prev_en = enable_n;
        for (t = 0; t < 400 && word_valid !== 1'b1; t++) begin
            if (load_n === 1'b0)
                load_low++;
            if (scan === 1'b1 && prev_scan === 1'b0)
                scans++;
            if (enable_n !== prev_en && (scan !== 1'b0 || prev_scan !== 1'b0))
                bad_en++;
            prev_scan = scan;
            prev_en = enable_n;
            clear_req = poke && (t == 50);
            @(negedge clk);
        end
        check("word_valid", 1'b1, word_valid);
        check("word", exp, word);
        check("cascade_err", exp_err, cascade_err);
        check("load_n low cycles", LOAD_LOW_CYC, load_low);
        check("scan pulses", NUM_BYTES, scans);
        check("enable_n moved with scan high", 0, bad_en);
        @(negedge clk);
        check("word_valid one cycle", 1'b0, word_valid);
        repeat (2) @(negedge clk);
        check("busy after read", 1'b0, busy);
    endtask

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic s_reset_state;
        check("pins idle", 5'h16, {cnt_reset_n, count_b, load_n, enable_n, scan});
        check("busy idle", 1'b0, busy);
        check("word idle", 32'h0000_0000, word);
    endtask

    task automatic s_clear_zero;
        pulse_a(5, 0);
        pulse_b(3);
        do_clear();
        do_read(32'h0000_0000, 1'b0, 1'b0);
    endtask

    task automatic s_count_both;
        pulse_a(16'h0305, 0);
        pulse_a(3, 1);
        pulse_b(16'h0201);
        do_read(32'h0201_0308, 1'b0, 1'b0);
    endtask

    // Held alternate input blocks the main one; its own release is one count
    task automatic s_inhibit_and_refuse;
        pulse_a(10, 2);
        do_read(32'h0201_0309, 1'b0, 1'b1);
        do_read(32'h0201_0309, 1'b0, 1'b0);
    endtask

    task automatic s_cascade;
        stuck_cascade = 1'b1;
        do_read(32'h0201_0309, 1'b1, 1'b0);
        stuck_cascade = 1'b0;
        do_read(32'h0201_0309, 1'b0, 1'b0);
    endtask

    // A request made while the clock enable is low must not start anything
    task automatic s_freeze;
        @(negedge clk);
        ce = 1'b0;
        read_req = 1'b1;
        repeat (3) @(negedge clk);
        check("busy while frozen", 1'b0, busy);
        check("load_n while frozen", 1'b1, load_n);
        read_req = 1'b0;
        ce = 1'b1;
        repeat (2) @(negedge clk);
        check("busy after freeze", 1'b0, busy);
        check("word_valid after freeze", 1'b0, word_valid);
    endtask

    // ==========================================================================
    // Main sequence and watchdog
    // ==========================================================================
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        clear_req = 1'b0;
        read_req = 1'b0;
        count_b_in = 1'b0;
        count_a = 1'b0;
        alt_count_a = 1'b0;
        stuck_cascade = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        s_reset_state();
        s_clear_zero();
        s_count_both();
        s_inhibit_and_refuse();
        s_cascade();
        s_freeze();
        print_verdict();
    end

    // Whole run is about 3500 cycles; more than five times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("[FAIL] watchdog expected finish seen timeout");
        print_verdict();
    end
endmodule // dual_counter_latch_byte_scanner_tb_top
